// file: design/chs_charge_ctrl.sv
// Charge start-up, watchdog, flags and ADC sequencing of the charger
`timescale 1ns/10ps
`default_nettype none
module chs_charge_ctrl
    import chs_pkg::*;
#(
    parameter int WDT_CYCLES = WDT_CYCLES_DEF,
    parameter int SS_STEP_CYCLES = SS_STEP_CYCLES_DEF
)(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire chs_host_req_t host,
    output logic [7:0] rd_data,
    // Analog comparators and strap
    input wire chs_sense_t sense,
    input wire logic strap_done,
    // ADC front end
    input wire logic [15:0] adc_sample,
    output logic [2:0] adc_channel,
    output logic adc_active,
    // Thresholds to the analog side
    output logic [THR_COUNT-1:0][7:0] thresholds,
    output logic [3:0] soft_start_current_target,
    // Power stage
    output chs_switch_t switches,
    // Open-drain interrupt pin
    output logic int_out,
    output logic int_oe_n
);

    // First enabled channel at or after a start index
    function automatic logic [3:0] next_ch(input logic [7:0] mask, input logic [3:0] from);
        logic [3:0] r;
        r = CH_NONE;
        for (int i = CH_COUNT - 1; i >= 0; i--)
        begin
            if (mask[i] && (4'(i) >= from))
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : next_ch

    logic access;
    logic wr_hit;
    logic [7:0] bus_window_check_status;
    logic [7:0] soft_start_undercurrent_config;
    logic [7:0] converter_control;
    logic [7:0] converter_channel_disable;
    logic [7:0] flags;
    logic [7:0] done;
    logic [15:0] result [CH_COUNT];
    logic chg_en;
    logic [31:0] wdt_cnt;
    logic wdt_expire;
    logic boot_fired;
    logic boot_pulse;
    logic alarm_prev;
    logic trip_prev;
    logic ss_timeout;
    logic [3:0] events;
    logic [7:0] int_cnt;
    chs_sw_state_t sw_state;
    logic [31:0] ss_cnt;
    logic [31:0] ss_limit;
    logic [7:0] ph_cnt;
    logic phase;
    logic sw_active;
    chs_adc_state_t adc_state;
    logic [3:0] adc_ch;
    logic [7:0] cyc_mask;
    logic [11:0] adc_timer;
    logic [11:0] conv_limit;
    logic supply_ok;
    logic conv_end;
    logic [3:0] ch_after;
    logic [3:0] ch_first;
    logic [7:0] next_rd;

    assign access = host.rd | host.wr;
    assign wr_hit = host.wr;
    assign sw_active = (sw_state != SW_IDLE);
    assign bus_window_check_status = {5'h00, sw_active, sense.bus_window_high_flag,
        sense.bus_window_low_flag};
    assign soft_start_current_target = soft_start_undercurrent_config[SS_TARGET_LSB +: 4];
    assign ss_limit = 32'(soft_start_undercurrent_config[SS_TIMEOUT_LSB +: 4] + 5'h01)
        * 32'(SS_STEP_CYCLES);
    assign supply_ok = sense.input_rail_present | sense.output_rail_present;
    assign conv_limit = 12'(ADC_CONV_CYCLES << converter_control[ADC_SPEED_LSB +: 2]);
    assign conv_end = (adc_state == ADC_CONV) && (adc_timer == conv_limit - 12'h001);
    assign ch_after = next_ch(cyc_mask, adc_ch + 4'h1);
    assign ch_first = next_ch(~converter_channel_disable, 4'h0);

    // Watchdog restarted by every access
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wdt_cnt <= '0;
            wdt_expire <= 1'b0;
        end
        else
        begin
            wdt_expire <= 1'b0;
            if (access)
            begin
                wdt_cnt <= '0;
            end
            else if (wdt_cnt == 32'(WDT_CYCLES - 1))
            begin
                wdt_cnt <= '0;
                wdt_expire <= 1'b1;
            end
            else
            begin
                wdt_cnt <= wdt_cnt + 32'h1;
            end
        end
    end

    // Event edges; a persisting level does not fire again
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            alarm_prev <= 1'b0;
            trip_prev <= 1'b0;
            boot_fired <= 1'b0;
            boot_pulse <= 1'b0;
        end
        else
        begin
            alarm_prev <= |sense.alarm;
            trip_prev <= |sense.trip;
            boot_pulse <= strap_done & ~boot_fired;
            if (strap_done)
            begin
                boot_fired <= 1'b1;
            end
        end
    end

    assign events = {ss_timeout, |sense.trip & ~trip_prev, |sense.alarm & ~alarm_prev,
        wdt_expire};

    // Sticky flags; a new event beats the clear of the read
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            flags <= FLAGS_RST;
        end
        else if (host.rd && host.addr == OFF_FLAGS)
        begin
            flags <= {4'h0, events};
        end
        else
        begin
            flags <= flags | {4'h0, events};
        end
    end

    // Interrupt pulse, stretched to a fixed width
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            int_cnt <= '0;
        end
        else if (boot_pulse || (|events))
        begin
            int_cnt <= 8'(INT_PULSE_CYCLES);
        end
        else if (int_cnt != 8'h00)
        begin
            int_cnt <= int_cnt - 8'h01;
        end
    end

    assign int_out = 1'b0;
    assign int_oe_n = (int_cnt == 8'h00);

    // Host writes to configuration
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            thresholds <= '{default: THR_RST};
            soft_start_undercurrent_config <= SS_CFG_RST;
            converter_channel_disable <= CH_DIS_RST;
        end
        else if (wr_hit)
        begin
            if (host.addr <= OFF_THR_LAST)
            begin
                thresholds[host.addr[3:0]] <= host.wdata;
            end
            if (host.addr == OFF_SS_CFG)
            begin
                soft_start_undercurrent_config <= host.wdata;
            end
            if (host.addr == OFF_CH_DIS)
            begin
                converter_channel_disable <= host.wdata;
            end
        end
    end

    // Charge enable; hardware stops override the host
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            chg_en <= 1'b0;
        end
        else if (wdt_expire || (|sense.trip) || ss_timeout
            || !sense.output_rail_above_hold)
        begin
            chg_en <= 1'b0;
        end
        else if (wr_hit && host.addr == OFF_CHG_CTRL)
        begin
            chg_en <= host.wdata[CHG_EN_BIT] & sense.output_rail_above_start;
        end
    end

    // Start-up sequence
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sw_state <= SW_IDLE;
            ss_cnt <= '0;
            ss_timeout <= 1'b0;
        end
        else
        begin
            ss_timeout <= 1'b0;
            unique case (sw_state)
                SW_IDLE:
                begin
                    ss_cnt <= '0;
                    // Enable drops one cycle after a timeout; no restart in between
                    if (chg_en && !ss_timeout && !sense.bus_window_low_flag
                        && !sense.bus_window_high_flag)
                    begin
                        sw_state <= SW_SOFT;
                    end
                end
                SW_SOFT:
                begin
                    ss_cnt <= ss_cnt + 32'h1;
                    if (!chg_en)
                    begin
                        sw_state <= SW_IDLE;
                    end
                    else if (sense.current_above_target)
                    begin
                        sw_state <= SW_RUN;
                    end
                    else if (ss_cnt == ss_limit - 32'h1)
                    begin
                        sw_state <= SW_IDLE;
                        ss_timeout <= 1'b1;
                    end
                end
                SW_RUN:
                begin
                    if (!chg_en)
                    begin
                        sw_state <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    // Two-phase drive at half duty
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ph_cnt <= '0;
            phase <= 1'b0;
            switches <= '0;
        end
        else
        begin
            if (!sw_active || ph_cnt == 8'(SW_HALF_CYCLES - 1))
            begin
                ph_cnt <= '0;
                phase <= sw_active & ~phase;
            end
            else
            begin
                ph_cnt <= ph_cnt + 8'h01;
            end
            switches.pair_a <= sw_active & phase;
            switches.pair_b <= sw_active & ~phase;
            switches.blocking_on <= sw_active & ~sense.blocking_over_limit;
        end
    end

    // ADC control: host write wins over the one-shot self clear
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            converter_control <= ADC_CTRL_RST;
        end
        else if (wr_hit && host.addr == OFF_ADC_CTRL)
        begin
            converter_control <= host.wdata;
        end
        else if (conv_end && ch_after == CH_NONE && converter_control[ADC_ONESHOT_BIT])
        begin
            converter_control[ADC_EN_BIT] <= 1'b0;
        end
    end

    // ADC sequencer; runs whatever the power stage does
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            adc_state <= ADC_IDLE;
            adc_ch <= '0;
            cyc_mask <= '0;
            adc_timer <= '0;
            done <= '0;
        end
        else if (!converter_control[ADC_EN_BIT])
        begin
            adc_state <= ADC_IDLE;
            adc_timer <= '0;
        end
        else
        begin
            unique case (adc_state)
                ADC_IDLE:
                begin
                    adc_timer <= '0;
                    if (supply_ok && ch_first != CH_NONE)
                    begin
                        adc_state <= ADC_CONV;
                        cyc_mask <= ~converter_channel_disable;
                        adc_ch <= ch_first;
                        done <= '0;
                    end
                end
                ADC_CONV:
                begin
                    adc_timer <= adc_timer + 12'h001;
                    if (conv_end)
                    begin
                        adc_timer <= '0;
                        done[adc_ch[2:0]] <= converter_control[ADC_ONESHOT_BIT];
                        if (&converter_channel_disable)
                        begin
                            adc_state <= ADC_IDLE;
                        end
                        else if (ch_after != CH_NONE)
                        begin
                            adc_ch <= ch_after;
                        end
                        else if (converter_control[ADC_ONESHOT_BIT])
                        begin
                            adc_state <= ADC_IDLE;
                        end
                        else
                        begin
                            cyc_mask <= ~converter_channel_disable;
                            adc_ch <= ch_first;
                        end
                    end
                end
            endcase
        end
    end

    // Results change only when their channel converts
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            result <= '{default: RESULT_RST};
        end
        else if (conv_end)
        begin
            if (converter_control[ADC_AVG_OFF_BIT])
            begin
                result[adc_ch[2:0]] <= adc_sample;
            end
            else
            begin
                result[adc_ch[2:0]] <= 16'(({1'b0, result[adc_ch[2:0]]}
                    + {1'b0, adc_sample}) >> 1);
            end
        end
    end

    assign adc_channel = adc_ch[2:0];
    assign adc_active = (adc_state == ADC_CONV);

    // Read mux
    always_comb
    begin
        next_rd = 8'h00;
        if (host.addr <= OFF_THR_LAST)
        begin
            next_rd = thresholds[host.addr[3:0]];
        end
        else if (host.addr >= OFF_RESULT && host.addr <= OFF_RESULT_LAST)
        begin
            next_rd = host.addr[0] ? result[host.addr[3:1]][15:8]
                : result[host.addr[3:1]][7:0];
        end
        else
        begin
            unique case (host.addr)
                OFF_WINDOW: next_rd = bus_window_check_status;
                OFF_CHG_CTRL: next_rd = {7'h00, chg_en};
                OFF_FLAGS: next_rd = flags;
                OFF_ADC_CTRL: next_rd = converter_control;
                OFF_CH_DIS: next_rd = converter_channel_disable;
                OFF_DONE: next_rd = converter_control[ADC_ONESHOT_BIT] ? done : 8'h00;
                OFF_SS_CFG: next_rd = soft_start_undercurrent_config;
                default: next_rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data <= 8'h00;
        end
        else if (host.rd)
        begin
            rd_data <= next_rd;
        end
    end

endmodule : chs_charge_ctrl
`default_nettype wire

// file: design/chs_pkg.sv
// Constants, register map and carrier types of the charge start and ADC control
package chs_pkg;
    // Register offsets
    localparam logic [7:0] OFF_THR_LAST = 8'h09;
    localparam logic [7:0] OFF_WINDOW = 8'h0a;
    localparam logic [7:0] OFF_CHG_CTRL = 8'h0b;
    localparam logic [7:0] OFF_FLAGS = 8'h0c;
    localparam logic [7:0] OFF_ADC_CTRL = 8'h0d;
    localparam logic [7:0] OFF_CH_DIS = 8'h0e;
    localparam logic [7:0] OFF_DONE = 8'h0f;
    localparam logic [7:0] OFF_RESULT = 8'h10;
    localparam logic [7:0] OFF_RESULT_LAST = 8'h1f;
    localparam logic [7:0] OFF_SS_CFG = 8'h2b;
    localparam int THR_COUNT = 10;
    localparam int CH_COUNT = 8;
    localparam logic [3:0] CH_NONE = 4'h8;

    // Field positions
    localparam int CHG_EN_BIT = 0;
    localparam int WIN_LOW_BIT = 0;
    localparam int WIN_HIGH_BIT = 1;
    localparam int WIN_ACTIVE_BIT = 2;
    localparam int FLAG_WDT_BIT = 0;
    localparam int FLAG_ALARM_BIT = 1;
    localparam int FLAG_TRIP_BIT = 2;
    localparam int FLAG_SS_BIT = 3;
    localparam int ADC_EN_BIT = 7;
    localparam int ADC_ONESHOT_BIT = 6;
    localparam int ADC_AVG_OFF_BIT = 5;
    localparam int ADC_SPEED_LSB = 3;
    localparam int SS_TIMEOUT_LSB = 0;
    localparam int SS_TARGET_LSB = 4;

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h01;
    localparam logic [7:0] ADC_CTRL_RST = 8'h00;
    localparam logic [7:0] CH_DIS_RST = 8'h00;
    localparam logic [7:0] SS_CFG_RST = 8'h00;
    localparam logic [7:0] THR_RST = 8'h00;
    localparam logic [15:0] RESULT_RST = 16'h0000;

    // Timing
    localparam int CLK_MHZ = 125;
    localparam int INT_PULSE_NS = 256;
    localparam int INT_PULSE_CYCLES = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int SW_HALF_NS = 1000;
    localparam int SW_HALF_CYCLES = SW_HALF_NS * CLK_MHZ / 1000;
    localparam int ADC_CONV_NS = 3000;
    localparam int ADC_CONV_CYCLES = (ADC_CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int WDT_MS = 40;
    localparam int WDT_CYCLES_DEF = WDT_MS * CLK_MHZ * 1000;
    localparam int SS_STEP_US = 100;
    localparam int SS_STEP_CYCLES_DEF = SS_STEP_US * CLK_MHZ;

    typedef enum logic [1:0] {SW_IDLE, SW_SOFT, SW_RUN} chs_sw_state_t;
    typedef enum logic {ADC_IDLE, ADC_CONV} chs_adc_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } chs_host_req_t;

    typedef struct packed {
        logic input_rail_present;
        logic output_rail_present;
        logic output_rail_above_start;
        logic output_rail_above_hold;
        logic bus_window_low_flag;
        logic bus_window_high_flag;
        logic blocking_over_limit;
        logic current_above_target;
        logic [3:0] trip;
        logic [4:0] alarm;
    } chs_sense_t;

    typedef struct packed {
        logic pair_a;
        logic pair_b;
        logic blocking_on;
    } chs_switch_t;
endpackage : chs_pkg

// file: testbench/chs_assertions.sv
// Port checker of the charge start and ADC control
`timescale 1ns/10ps
`default_nettype none
module chs_checker
    import chs_pkg::*;
#(
    parameter int WDT_CYCLES = 200,
    parameter int SS_STEP_CYCLES = 20
)(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire chs_host_req_t host,
    input wire logic [7:0] rd_data,
    // Analog side and ADC
    input wire chs_sense_t sense,
    input wire logic strap_done,
    input wire logic [15:0] adc_sample,
    input wire logic [2:0] adc_channel,
    input wire logic adc_active,
    input wire logic [THR_COUNT-1:0][7:0] thresholds,
    input wire logic [3:0] soft_start_current_target,
    // Power stage and interrupt pin
    input wire chs_switch_t switches,
    input wire logic int_out,
    input wire logic int_oe_n
);
    int wd_cnt;
    logic sw_off;
    logic out_win;
    logic no_supply;
    assign sw_off = !switches.pair_a && !switches.pair_b && !switches.blocking_on;
    assign out_win = sense.bus_window_low_flag || sense.bus_window_high_flag;
    assign no_supply = !sense.input_rail_present && !sense.output_rail_present;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    // Saturating idle count, so a long quiet run cannot wrap
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            wd_cnt <= 0;
        else if (host.rd || host.wr)
            wd_cnt <= 0;
        else if (wd_cnt < WDT_CYCLES + 8)
            wd_cnt <= wd_cnt + 1;
    end
    pair_overlap_a: assert property (!(switches.pair_a && switches.pair_b))
        else $error("switch pairs on together");
    int_width_a: assert property ($fell(int_oe_n) |-> ##31 !int_oe_n)
        else $error("interrupt pulse too short");
    trip_stop_a: assert property ((|sense.trip) [*4] |-> sw_off)
        else $error("switching went on during a trip");
    block_limit_a: assert property (sense.blocking_over_limit [*2] |-> !switches.blocking_on)
        else $error("blocking switch on above limit");
    window_hold_a: assert property ((out_win && sw_off) [*3] |=> sw_off)
        else $error("start outside the bus window");
    wdt_stop_a: assert property (wd_cnt > WDT_CYCLES + 4 |-> sw_off)
        else $error("switching after watchdog expiry");
    adc_stop_a: assert property (host.wr && host.addr == OFF_ADC_CTRL &&
        !host.wdata[ADC_EN_BIT] |-> ##[1:2] !adc_active)
        else $error("converter ran on after disable");
    adc_defer_a: assert property (!adc_active && no_supply |=> !adc_active)
        else $error("conversion without a supply");
    cover property ($rose(switches.pair_a));
    cover property ($fell(int_oe_n));
    cover property ($rose(adc_active));
endmodule : chs_checker

bind chs_charge_ctrl chs_checker #(.WDT_CYCLES(WDT_CYCLES), .SS_STEP_CYCLES(SS_STEP_CYCLES)) chk (
    .clock(clock), .nrst(nrst), .host(host), .rd_data(rd_data), .sense(sense),
    .strap_done(strap_done), .adc_sample(adc_sample), .adc_channel(adc_channel),
    .adc_active(adc_active), .thresholds(thresholds),
    .soft_start_current_target(soft_start_current_target), .switches(switches),
    .int_out(int_out), .int_oe_n(int_oe_n));
`default_nettype wire

// file: testbench/chs_charge_ctrl_tb.sv
// Self-checking bench of the charge start and ADC control
`timescale 1ns/10ps
`default_nettype none
module chs_charge_ctrl_tb;
    import chs_pkg::*;
    localparam int WDT = 2000;
    logic clock;
    logic nrst;
    chs_host_req_t host;
    logic [7:0] rd_data;
    chs_sense_t sense;
    logic strap_done;
    logic [15:0] adc_sample;
    logic [2:0] adc_channel;
    logic adc_active;
    logic [THR_COUNT-1:0][7:0] thresholds;
    logic [3:0] sct;
    chs_switch_t switches;
    logic int_out;
    logic int_oe_n;
    logic int_pin;
    logic rd_seen;
    logic [15:0] note;
    logic [15:0] notes [$];
    logic [7:0] d;
    logic [7:0] v;
    bit ok;
    int err_count;
    int checked;
    int seed;
    int i;
    int n;
    assign int_pin = int_oe_n ? 1'b1 : int_out;
    // Sample follows the channel, so each result is known
    assign adc_sample = {5'h00, adc_channel, 5'h1a, adc_channel};
    chs_charge_ctrl #(.WDT_CYCLES(WDT), .SS_STEP_CYCLES(20)) DUT (.clock(clock), .nrst(nrst),
        .host(host), .rd_data(rd_data), .sense(sense), .strap_done(strap_done),
        .adc_sample(adc_sample), .adc_channel(adc_channel), .adc_active(adc_active),
        .thresholds(thresholds), .soft_start_current_target(sct), .switches(switches),
        .int_out(int_out), .int_oe_n(int_oe_n));
    chs_host_model hm (.clock(clock), .host(host), .rd_data(rd_data), .int_pin(int_pin));
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask : check
    task automatic rc(input logic [7:0] a, m, e);
        notes.push_back({m, e});
        hm.rd(a, d);
    endtask : rc
    task automatic conclude;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // Read data stands from the edge after the strobe
    always @(posedge clock)
    begin
        if (rd_seen)
        begin
            note = notes.pop_front();
            check("rd_data", {8'h00, rd_data & note[15:8]}, {8'h00, note[7:0]});
        end
        rd_seen <= host.rd;
    end
    initial
    begin
        seed = 32'he982;
        err_count = 0;
        checked = 0;
        rd_seen = 1'b0;
        nrst = 1'b0;
        strap_done = 1'b0;
        sense = '0;
        sense.input_rail_present = 1'b1;
        sense.output_rail_above_start = 1'b1;
        sense.output_rail_above_hold = 1'b1;
        cyc(16);
        check("int_oe_n", int_oe_n, 1'b1);
        nrst = 1'b1;
        cyc(4);
        strap_done = 1'b1;
        hm.wait_int(ok);
        check("first_int", ok, 1'b1);
        rc(OFF_FLAGS, 8'hff, FLAGS_RST);
        rc(OFF_FLAGS, 8'hff, 8'h00);
        rc(OFF_CHG_CTRL, 8'h01, 8'h00);
        rc(OFF_SS_CFG, 8'hff, SS_CFG_RST);
        rc(8'h20, 8'hff, 8'h00);
        // Protections programmed before any enable
        for (i = 0; i < THR_COUNT; i++)
        begin
            v = $random(seed);
            hm.wr(i[7:0], v);
            check("threshold", thresholds[i], v);
        end
        sense.output_rail_above_start = 1'b0;
        hm.wr(OFF_CHG_CTRL, 8'h01);
        rc(OFF_CHG_CTRL, 8'h01, 8'h00);
        sense.output_rail_above_start = 1'b1;
        sense.bus_window_low_flag = 1'b1;
        hm.wr(OFF_CHG_CTRL, 8'h01);
        cyc(4);
        rc(OFF_WINDOW, 8'h07, 8'h01);
        check("blocking", switches.blocking_on, 1'b0);
        sense.bus_window_low_flag = 1'b0;
        cyc(4);
        rc(OFF_WINDOW, 8'h04, 8'h04);
        check("blocking", switches.blocking_on, 1'b1);
        sense.blocking_over_limit = 1'b1;
        cyc(2);
        check("blocking", switches.blocking_on, 1'b0);
        sense.blocking_over_limit = 1'b0;
        cyc(30);
        rc(OFF_CHG_CTRL, 8'h01, 8'h00);
        rc(OFF_FLAGS, 8'h08, 8'h08);
        check("switches", switches, 3'b000);
        hm.wr(OFF_SS_CFG, 8'h50);
        check("target", sct, 4'h5);
        sense.current_above_target = 1'b1;
        hm.wr(OFF_CHG_CTRL, 8'h01);
        for (n = 0; n < 400 && !switches.pair_b; n++)
            cyc(1);
        for (n = 0; n < 400 && !switches.pair_a; n++)
            cyc(1);
        for (n = 0; n < 400 && switches.pair_a; n++)
            cyc(1);
        check("half_period", n, SW_HALF_CYCLES);
        check("pair_b", switches.pair_b, 1'b1);
        sense.alarm = 5'h01;
        cyc(3);
        check("int_oe_n", int_oe_n, 1'b0);
        check("running", switches.pair_a ^ switches.pair_b, 1'b1);
        rc(OFF_FLAGS, 8'h02, 8'h02);
        cyc(40);
        check("int_oe_n", int_oe_n, 1'b1);
        rc(OFF_FLAGS, 8'h02, 8'h00);
        sense.alarm = 5'h00;
        sense.output_rail_above_hold = 1'b0;
        cyc(4);
        rc(OFF_CHG_CTRL, 8'h01, 8'h00);
        sense.output_rail_above_hold = 1'b1;
        hm.wr(OFF_CHG_CTRL, 8'h01);
        cyc(4);
        sense.trip = 4'h2;
        cyc(5);
        check("switches", switches, 3'b000);
        rc(OFF_FLAGS, 8'h04, 8'h04);
        sense.trip = 4'h0;
        hm.wr(OFF_CHG_CTRL, 8'h01);
        cyc(WDT - 50);
        rc(OFF_CHG_CTRL, 8'h01, 8'h01);
        cyc(WDT - 50);
        check("running", switches.pair_a ^ switches.pair_b, 1'b1);
        cyc(100);
        check("switches", switches, 3'b000);
        rc(OFF_FLAGS, 8'h01, 8'h01);
        // One-shot, no averaging, channel one left out
        sense.input_rail_present = 1'b0;
        hm.wr(OFF_CH_DIS, 8'h02);
        hm.wr(OFF_ADC_CTRL, 8'he0);
        cyc(10);
        check("adc_active", adc_active, 1'b0);
        sense.output_rail_present = 1'b1;
        cyc(4);
        check("adc_active", adc_active, 1'b1);
        sense.trip = 4'h1;
        cyc(500);
        check("adc_active", adc_active, 1'b1);
        sense.trip = 4'h0;
        // Last read was the flag register; its bit 7 must not end the poll
        d = 8'hff;
        for (n = 0; n < 80 && d[ADC_EN_BIT] !== 1'b0; n++)
        begin
            cyc(100);
            rc(OFF_ADC_CTRL, 8'h00, 8'h00);
        end
        rc(OFF_ADC_CTRL, 8'h80, 8'h00);
        rc(OFF_RESULT, 8'hff, 8'hd0);
        rc(OFF_RESULT + 8'h02, 8'hff, 8'h00);
        rc(OFF_RESULT_LAST, 8'hff, 8'h07);
        rc(OFF_DONE, 8'hff, 8'hfd);
        hm.wr(OFF_CH_DIS, 8'hff);
        hm.wr(OFF_ADC_CTRL, 8'h80);
        cyc(500);
        check("adc_active", adc_active, 1'b0);
        hm.wr(OFF_CH_DIS, 8'h00);
        cyc(3);
        check("adc_active", adc_active, 1'b1);
        cyc(3200);
        rc(OFF_DONE, 8'hff, 8'h00);
        hm.wr(OFF_ADC_CTRL, 8'h00);
        cyc(1);
        check("adc_active", adc_active, 1'b0);
        conclude();
    end
endmodule : chs_charge_ctrl_tb
`default_nettype wire

// file: testbench/chs_host_model.sv
// Host processor model driving the register port
`timescale 1ns/10ps
`default_nettype none
module chs_host_model
    import chs_pkg::*;
(
    // Clock
    input wire logic clock,
    // Register port
    output var chs_host_req_t host,
    input wire logic [7:0] rd_data,
    // Interrupt pin level
    input wire logic int_pin
);
    initial
    begin
        host = '0;
    end
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        host.rd = 1'b1;
        host.addr = a;
        @(posedge clock);
        #1;
        host.rd = 1'b0;
        d = rd_data;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        #1;
        host.wr = 1'b1;
        host.addr = a;
        host.wdata = v;
        @(posedge clock);
        #1;
        host.wr = 1'b0;
    endtask : wr
    // Quiet until the first interrupt pulse
    task automatic wait_int(output bit ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 500 && !ok; i++)
        begin
            @(posedge clock);
            ok = !int_pin;
        end
    endtask : wait_int
endmodule : chs_host_model
`default_nettype wire
